// ### hdl/rpf_pkg.sv
// What this block does
// R1 - Word for pattern bytes 50-51, fed outward
// R2 - Word for bytes 62-63 ends 64-byte pattern
// R3 - Seven pattern words at indices 155h-15Bh
// R4 - Each byte maskable on its own
// R5 - Mask bit one drops byte from match
// R6 - First mask word covers bytes 0-15
// R7 - Second mask word covers bytes 16-31
// R8 - Third mask word covers bytes 32-47
// R9 - Fourth mask word, bytes 48-63, at 15Fh
// R10 - Reset clears all words to zero
// R11 - Bit n is nth byte; even byte low
//
// Purpose: constants for the receive match tail register bank
// Assumes: word index times four gives the AHB byte address
// Notes: indices are word numbers, not byte addresses
package rpf_pkg;

	// ------------------------------------------------------------
	// Register word indices
	// ------------------------------------------------------------
	localparam logic [9:0] IDX_PAT_50_51 = 10'h155;
	localparam logic [9:0] IDX_PAT_52_53 = 10'h156;
	localparam logic [9:0] IDX_PAT_54_55 = 10'h157;
	localparam logic [9:0] IDX_PAT_56_57 = 10'h158;
	localparam logic [9:0] IDX_PAT_58_59 = 10'h159;
	localparam logic [9:0] IDX_PAT_60_61 = 10'h15A;
	localparam logic [9:0] IDX_PAT_62_63 = 10'h15B;
	localparam logic [9:0] IDX_IGN_0_15 = 10'h15C;
	localparam logic [9:0] IDX_IGN_16_31 = 10'h15D;
	localparam logic [9:0] IDX_IGN_32_47 = 10'h15E;
	localparam logic [9:0] IDX_IGN_48_63 = 10'h15F;

	// ------------------------------------------------------------
	// Sizes, slots, reset value, bus codes
	// ------------------------------------------------------------
	localparam int NUM_WORDS = 11;
	localparam int NUM_PAT = 7;
	localparam logic [15:0] WORD_RESET = 16'h0000;
	localparam logic [2:0] HSIZE_WORD = 3'h2;

	// One-hot bus front states
	typedef enum logic [3:0]
	{
		ST_IDLE = 4'b0001,
		ST_WDATA = 4'b0010,
		ST_RWAIT = 4'b0100,
		ST_RDATA = 4'b1000
	} rpf_state_t;

	// Index to {hit, slot}; slots 0-6 pattern, 7-10 mask
	function automatic logic [4:0] rpf_decode(input logic [9:0] idx);
		logic [9:0] diff;
		diff = idx - IDX_PAT_50_51;
		rpf_decode = {(idx >= IDX_PAT_50_51) && (idx <= IDX_IGN_48_63),
			diff[3:0]}; // R3
	endfunction

endpackage

// ### hdl/rpf_acc_if.sv
// Purpose: register access carrier between bus front and bank
// Assumes: one access strobe per cycle
// Notes: legal low means above 4 KB, misaligned or not a word access
`timescale 1ns/1ps
interface rpf_acc_if;
	logic wr_stb;
	logic rd_stb;
	logic legal;
	logic [9:0] idx;
	logic [15:0] wdata;
	logic [15:0] rdata;
	modport front (output wr_stb, rd_stb, legal, idx, wdata, input rdata);
	modport bank (input wr_stb, rd_stb, legal, idx, wdata, output rdata);
endinterface

// ### hdl/rpf_ahb_front.sv
// Purpose: AHB-Lite slave front for the match tail bank
// Assumes: single word transfers, one slave on the bus
// Notes: reads take one wait state, writes none
`timescale 1ns/1ps
module rpf_ahb_front
(
	// Clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// AHB-Lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic [31:0] hrdata,
	// Bank access
	rpf_acc_if.front acc
);

	rpf_pkg::rpf_state_t state;
	rpf_pkg::rpf_state_t next_state;
	logic [9:0] a_idx;
	logic a_legal;
	logic take;
	logic addr_ok;

	// ------------------------------------------------------------
	// Address phase decode
	// ------------------------------------------------------------
	assign take = hsel & htrans[1] & hready;
	assign addr_ok = (haddr[31:12] == 20'h00000) && (haddr[1:0] == 2'h0)
		&& (hsize == rpf_pkg::HSIZE_WORD);

	// Strobes toward the bank
	assign acc.wr_stb = (state == rpf_pkg::ST_WDATA);
	assign acc.rd_stb = (state == rpf_pkg::ST_RWAIT);
	assign acc.legal = a_legal;
	assign acc.idx = a_idx;
	assign acc.wdata = hwdata[15:0];

	// Next state
	always_comb
	begin
		case (state)
			rpf_pkg::ST_RWAIT: next_state = rpf_pkg::ST_RDATA;
			default:
				if (take)
					next_state = hwrite ? rpf_pkg::ST_WDATA : rpf_pkg::ST_RWAIT;
				else
					next_state = rpf_pkg::ST_IDLE;
		endcase
	end

	// State, ready and address capture
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			state <= rpf_pkg::ST_IDLE;
			hreadyout <= 1'b1;
			a_idx <= 10'h000;
			a_legal <= 1'b0;
		end
		else
		begin
			state <= next_state;
			hreadyout <= (next_state != rpf_pkg::ST_RWAIT);
			if (take)
			begin
				a_idx <= haddr[11:2];
				a_legal <= addr_ok;
			end
		end
	end

	// Read data loaded in the wait state
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			hrdata <= 32'h00000000;
		else if (state == rpf_pkg::ST_RWAIT)
			hrdata <= {16'h0000, acc.rdata};
	end

endmodule // rpf_ahb_front

// ### hdl/rpf_filter_regs.sv
// Purpose: receive match pattern tail and byte mask registers
// Assumes: AHB-Lite master, single word transfers
// Notes: pattern and mask outputs feed the frame comparator
`timescale 1ns/1ps
module rpf_filter_regs
(
	// Clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// AHB-Lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic [31:0] hrdata,
	output logic hresp,
	// Toward the frame comparator
	output logic [111:0] rx_match_pattern_tail,
	output logic [63:0] receive_match_ignore_bits
);

	// ------------------------------------------------------------
	// Storage and decode
	// ------------------------------------------------------------
	rpf_acc_if acc ();
	logic [15:0] bank [rpf_pkg::NUM_WORDS];
	logic [4:0] dec;
	logic hit;
	logic [3:0] slot;
	logic wr_go;

	// Bus front
	rpf_ahb_front u_front
	(
		.hclk(hclk),
		.hresetn(hresetn),
		.hsel(hsel),
		.haddr(haddr),
		.htrans(htrans),
		.hwrite(hwrite),
		.hsize(hsize),
		.hwdata(hwdata),
		.hready(hready),
		.hreadyout(hreadyout),
		.hrdata(hrdata),
		.acc(acc.front)
	);

	// Captured index to slot
	assign dec = rpf_pkg::rpf_decode(acc.idx); // R3
	assign hit = acc.legal & dec[4];
	assign slot = dec[3:0];
	assign wr_go = acc.wr_stb & hit;

	// Read selection, unmapped reads as zero
	assign acc.rdata = hit ? bank[slot] : 16'h0000;

	// ------------------------------------------------------------
	// Register bank
	// ------------------------------------------------------------
	// Each word written whole, others untouched
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			for (int i = 0; i < rpf_pkg::NUM_WORDS; i++)
				bank[i] <= rpf_pkg::WORD_RESET; // R10
		end
		else if (wr_go)
			bank[slot] <= acc.wdata; // R4
	end

	// Response is always OKAY
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			hresp <= 1'b0;
		else
			hresp <= 1'b0;
	end

	// ------------------------------------------------------------
	// Outputs to the comparator
	// ------------------------------------------------------------
	// Byte 50 at bits 7:0, byte 63 at bits 111:104
	assign rx_match_pattern_tail = {bank[6], bank[5], bank[4], bank[3],
		bank[2], bank[1], bank[0]}; // R1 R2 R11
	// Bit n is byte n; one drops the byte from the match
	assign receive_match_ignore_bits = {bank[10], bank[9], bank[8],
		bank[7]}; // R5 R6 R7 R8 R9

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	default clocking cb @(posedge hclk);
	endclocking
	default disable iff (!hresetn);

	// Helper terms seen from the bus
	logic rd_take;
	logic wr_take;
	logic [111:0] pat_q;
	logic [63:0] ign_q;
	assign rd_take = hsel & htrans[1] & hready & !hwrite;
	assign wr_take = hsel & htrans[1] & hready & hwrite;
	assign pat_q = rx_match_pattern_tail;
	assign ign_q = receive_match_ignore_bits;

	// A write data phase to one index
	sequence s_write(logic [9:0] c);
		acc.wr_stb && acc.legal && (acc.idx == c);
	endsequence

	// A read wait cycle on one index
	sequence s_read(logic [9:0] c);
		acc.rd_stb && acc.legal && (acc.idx == c);
	endsequence

	// First pattern word takes the data, low byte is byte 50
	property p_pat_first_write;
		logic [15:0] d;
		(s_write(rpf_pkg::IDX_PAT_50_51), d = acc.wdata)
		|=> (pat_q[7:0] == d[7:0]) && (pat_q[15:8] == d[15:8]);
	endproperty
	a_pat_first_write: assert property (p_pat_first_write) // R1 R11
		else $error("pattern word 50-51 not updated");

	// Last pattern word lands in the top bits
	property p_pat_last_write;
		logic [15:0] d;
		(s_write(rpf_pkg::IDX_PAT_62_63), d = acc.wdata)
		|=> (pat_q[111:96] == d) && (pat_q[95:0] == $past(pat_q[95:0]));
	endproperty
	a_pat_last_write: assert property (p_pat_last_write) // R2
		else $error("pattern word 62-63 not updated");

	// Pattern word 62-63 reads back after one wait state
	property p_pat_readback;
		s_read(rpf_pkg::IDX_PAT_62_63)
		|=> hreadyout && (hrdata == {16'h0000, $past(pat_q[111:96])});
	endproperty
	a_pat_readback: assert property (p_pat_readback) // R3
		else $error("pattern word 62-63 read back wrong");

	// Middle pattern word sits at its own index
	property p_pat_mid_write;
		logic [15:0] d;
		(s_write(rpf_pkg::IDX_PAT_56_57), d = acc.wdata)
		|=> (pat_q[63:48] == d) && (ign_q == $past(ign_q));
	endproperty
	a_pat_mid_write: assert property (p_pat_mid_write) // R3
		else $error("pattern word 56-57 misplaced");

	// A mask write touches no pattern byte and no other mask word
	property p_mask_isolated;
		s_write(rpf_pkg::IDX_IGN_16_31)
		|=> (pat_q == $past(pat_q)) && (ign_q[15:0] == $past(ign_q[15:0]))
			&& (ign_q[63:32] == $past(ign_q[63:32]));
	endproperty
	a_mask_isolated: assert property (p_mask_isolated) // R4
		else $error("mask write disturbed other words");

	// Writing one to the top mask bit masks byte 63
	property p_mask_one_masks;
		s_write(rpf_pkg::IDX_IGN_48_63) ##0 acc.wdata[15]
		|=> receive_match_ignore_bits[63];
	endproperty
	a_mask_one_masks: assert property (p_mask_one_masks) // R5
		else $error("byte 63 not masked after write of one");

	// First mask word maps bit n to byte n
	property p_mask_0_15;
		logic [15:0] d;
		(s_write(rpf_pkg::IDX_IGN_0_15), d = acc.wdata)
		|=> ign_q[15:0] == d;
	endproperty
	a_mask_0_15: assert property (p_mask_0_15) // R6 R11
		else $error("mask bytes 0-15 wrong");

	// Second mask word covers bytes 16 to 31
	property p_mask_16_31;
		logic [15:0] d;
		(s_write(rpf_pkg::IDX_IGN_16_31), d = acc.wdata)
		|=> ign_q[31:16] == d;
	endproperty
	a_mask_16_31: assert property (p_mask_16_31) // R7
		else $error("mask bytes 16-31 wrong");

	// Third mask word covers bytes 32 to 47
	property p_mask_32_47;
		logic [15:0] d;
		(s_write(rpf_pkg::IDX_IGN_32_47), d = acc.wdata)
		|=> ign_q[47:32] == d;
	endproperty
	a_mask_32_47: assert property (p_mask_32_47) // R8
		else $error("mask bytes 32-47 wrong");

	// Fourth mask word reads back from index 15Fh
	property p_mask_48_63_read;
		s_read(rpf_pkg::IDX_IGN_48_63)
		|=> hrdata == {16'h0000, $past(ign_q[63:48])};
	endproperty
	a_mask_48_63_read: assert property (p_mask_48_63_read) // R9
		else $error("mask bytes 48-63 read back wrong");

	// Bank and read data are zero and ready is high in the first cycle after reset
	property p_reset_zero;
		!$past(hresetn) |-> (pat_q == 112'h0) && (ign_q == 64'h0)
			&& hreadyout && (hrdata == 32'h00000000);
	endproperty
	a_reset_zero: assert property (p_reset_zero) // R10
		else $error("bank not cleared by reset");

	// A read holds ready low for exactly one cycle
	property p_read_wait;
		rd_take |=> !hreadyout ##1 hreadyout;
	endproperty
	a_read_wait: assert property (p_read_wait)
		else $error("read wait state wrong");

	// A write never stalls the bus
	property p_write_no_wait;
		wr_take |=> hreadyout [*1] ##0 acc.wr_stb;
	endproperty
	a_write_no_wait: assert property (p_write_no_wait)
		else $error("write data phase stalled");

	// Unmapped reads answer zero
	property p_unmapped_read;
		acc.rd_stb && !hit |=> hrdata == 32'h00000000;
	endproperty
	a_unmapped_read: assert property (p_unmapped_read)
		else $error("unmapped read not zero");

	// Unmapped writes leave the bank untouched
	property p_unmapped_write;
		acc.wr_stb && !hit |=> (pat_q == $past(pat_q))
			&& (ign_q == $past(ign_q));
	endproperty
	a_unmapped_write: assert property (p_unmapped_write)
		else $error("unmapped write changed the bank");

	// Bank only changes on a mapped write
	property p_no_spurious_change;
		!wr_go |=> (pat_q == $past(pat_q)) && (ign_q == $past(ign_q));
	endproperty
	a_no_spurious_change: assert property (p_no_spurious_change) // R4
		else $error("bank changed without a write");

	// Response stays OKAY
	property p_resp_okay;
		hreadyout |-> !hresp;
	endproperty
	a_resp_okay: assert property (p_resp_okay)
		else $error("error response seen");

endmodule // rpf_filter_regs

// ### verif/tb_top.sv
// Purpose: self-checking bench for the match tail register bank
// Assumes: single word AHB-Lite transfers, hready tied to hreadyout
// Notes: expectations come from the row table, not from the design
`timescale 1ns/1ps
module tb_top;
	typedef struct {logic [9:0] idx; logic [31:0] wd; logic [15:0] exp;} rpf_row_t;

	// ------------------------------------------------------------
	// Signals
	// ------------------------------------------------------------
	logic hclk, hresetn, hsel, hwrite, hreadyout, hresp;
	logic [31:0] haddr, hwdata, hrdata, rd;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic [111:0] pat, exp_pat;
	logic [63:0] ign, exp_ign;
	logic [31:0] bad_a [4];
	rpf_row_t rows [11];
	int errors, cmp_count;

	// Design under test, single slave so hready is its own hreadyout
	rpf_filter_regs uut
	(
		.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize),
		.hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
		.hrdata(hrdata), .hresp(hresp),
		.rx_match_pattern_tail(pat), .receive_match_ignore_bits(ign)
	);

	// 200 MHz clock
	initial
	begin
		hclk = 1'b0;
		forever #2.5 hclk = ~hclk;
	end

	// ------------------------------------------------------------
	// Tasks
	// ------------------------------------------------------------
	// Counts and verdict, ends the run
	task wrap_up;
		begin
			$display("Comparisons %0d mismatches %0d", cmp_count, errors);
			if (errors == 0 && cmp_count > 0)
				$display("ALL TESTS PASSED");
			else
				$display("TESTS FAILED");
			$finish;
		end
	endtask

	// One compare, reports a mismatch at once
	task chk(input string nm, input logic [111:0] e, input logic [111:0] g);
		begin
			cmp_count++;
			if (g !== e)
			begin
				$display("BAD %s expected %h seen %h", nm, e, g);
				errors++;
			end
		end
	endtask

	// Single AHB transfer; entered just after a rising edge
	task bus(input logic w, input logic [31:0] a, input logic [2:0] sz,
		input logic [31:0] wd, output logic [31:0] r);
		int n;
		logic rdy;
		begin
			hsel <= 1'b1;
			haddr <= a;
			htrans <= 2'h2;
			hwrite <= w;
			hsize <= sz;
			for (int ph = 0; ph < 2; ph++)
			begin
				n = 0;
				rdy = 1'b0;
				while (rdy !== 1'b1)
				begin
					@(negedge hclk);
					rdy = hreadyout;
					r = hrdata;
					@(posedge hclk);
					n++;
					if (n > 50)
					begin
						errors++;
						wrap_up();
					end
				end
				if (ph == 0)
				begin
					htrans <= 2'h0;
					hsel <= 1'b0;
					hwdata <= wd;
				end
			end
		end
	endtask

	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial
	begin
		hresetn = 1'b0;
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h0;
		errors = 0;
		cmp_count = 0;
		bad_a = '{32'h0000_0550, 32'h0000_0580, 32'h0000_1554, 32'h0000_0556};
		for (int i = 0; i < 11; i++)
		begin
			rows[i].idx = 10'h155 + 10'(i);
			rows[i].exp = {8'(8'h1F * i + 8'h0F), 8'(8'hC0 + i)};
			rows[i].wd = {16'hDEAD, rows[i].exp};
		end
		repeat (20) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		chk("pattern after reset", 112'h0, pat);
		chk("mask after reset", 112'h0, 112'(ign));
		// Row loop: reset read, write, comparator slice, readback
		for (int i = 0; i < 11; i++)
		begin
			bus(1'b0, {20'h0, rows[i].idx, 2'h0}, 3'h2, 32'h0, rd);
			chk("reset read", 112'h0, 112'(rd));
			bus(1'b1, {20'h0, rows[i].idx, 2'h0}, 3'h2, rows[i].wd, rd);
			@(negedge hclk);
			chk("slice", 112'(rows[i].exp), (i < 7) ? 112'(pat[16*i+:16])
				: 112'(ign[16*(i-7)+:16]));
			@(posedge hclk);
			bus(1'b0, {20'h0, rows[i].idx, 2'h0}, 3'h2, 32'h0, rd);
			chk("readback", 112'(rows[i].exp), 112'(rd));
			chk("response", 112'h0, 112'(hresp));
		end
		for (int i = 0; i < 7; i++)
			exp_pat[16*i+:16] = rows[i].exp;
		for (int i = 0; i < 4; i++)
			exp_ign[16*i+:16] = rows[i+7].exp;
		chk("whole pattern", exp_pat, pat);
		chk("whole mask", 112'(exp_ign), 112'(ign));
		// Unmapped, out of range and misaligned writes are dropped
		for (int i = 0; i < 4; i++)
		begin
			bus(1'b1, bad_a[i], 3'h2, 32'h0000_FFFF, rd);
			bus(1'b0, bad_a[i], 3'h2, 32'h0, rd);
			chk("unmapped read", 112'h0, 112'(rd));
		end
		bus(1'b1, 32'h0000_0554, 3'h1, 32'h0000_7777, rd);
		@(negedge hclk);
		chk("pattern kept", exp_pat, pat);
		chk("mask kept", 112'(exp_ign), 112'(ign));
		// All bytes 48 to 63 masked, other mask words untouched
		@(posedge hclk);
		bus(1'b1, 32'h0000_057C, 3'h2, 32'h0000_FFFF, rd);
		bus(1'b0, 32'h0000_057C, 3'h2, 32'h0, rd);
		chk("full mask read", 112'h0000_FFFF, 112'(rd));
		exp_ign[63:48] = 16'hFFFF;
		chk("full mask out", 112'(exp_ign), 112'(ign));
		// Second reset in mid-run
		hresetn <= 1'b0;
		repeat (3) @(posedge hclk);
		@(negedge hclk);
		chk("pattern mid reset", 112'h0, pat);
		chk("mask mid reset", 112'h0, 112'(ign));
		@(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		bus(1'b0, 32'h0000_0554, 3'h2, 32'h0, rd);
		chk("read after reset", 112'h0, 112'(rd));
		wrap_up();
	end
endmodule // tb_top
